// File: src/ifr_flag_regs.sv
/*
 * Two 16-bit interrupt flag status registers behind an Avalon-MM slave,
 * plus a sticky event status / mask pair driving one level interrupt.
 * Assumes peripheral request lines are synchronous to ref_clk_in and that
 * the bus master holds its request until it samples waitrequest low.
 */
// Implementation choices: the Avalon-MM register port and the placing of the registers.
module ifr_flag_regs (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_n_in,
    input  wire ifr_pkg::ifr_avs_req_t avs_req_in,
    input  wire logic [15:0]           req_grp0_in,
    input  wire logic [15:0]           req_grp1_in,
    output logic                       avs_waitrequest_out,
    output logic [31:0]                avs_readdata_out,
    output logic [15:0]                flags_grp0_out,
    output logic [15:0]                flags_grp1_out,
    output logic                       irq_out
);

    ifr_pkg::ifr_state_t q;
    ifr_pkg::ifr_state_t d;

    logic        bus_req;
    logic        wr_take;
    logic        rd_take;
    logic [15:0] lane_mask;
    logic [15:0] hw_set0;
    logic [15:0] hw_set1;
    logic [1:0]  ev;
    logic [31:0] rd_val;

    // Request line i is source vector i, landing on flag bit i
    assign hw_set0 = req_grp0_in & ifr_pkg::IMPL0;
    assign hw_set1 = req_grp1_in & ifr_pkg::IMPL1;

    // Event: any implemented source of a group raising a request
    assign ev[ifr_pkg::EV_GRP0] = |hw_set0;
    assign ev[ifr_pkg::EV_GRP1] = |hw_set1;

    assign bus_req   = avs_req_in.read | avs_req_in.write;
    // Accesses take effect only on the edge where waitrequest is seen low
    assign wr_take   = avs_req_in.write & (q.st == ifr_pkg::ST_ANS);
    assign rd_take   = avs_req_in.read & (q.st == ifr_pkg::ST_ANS);
    assign lane_mask = {{8{avs_req_in.byteenable[1]}}, {8{avs_req_in.byteenable[0]}}};

    // Read mux; unmapped offsets and unimplemented bits read as zero
    always_comb begin
        case (avs_req_in.address)
            ifr_pkg::FLAGS0_OFS: rd_val = {16'h0000, q.flags0};
            ifr_pkg::FLAGS1_OFS: rd_val = {16'h0000, q.flags1};
            ifr_pkg::STAT_OFS:   rd_val = {30'h0, q.stat};
            ifr_pkg::MASK_OFS:   rd_val = {30'h0, q.mask};
            default:             rd_val = 32'h0000_0000;
        endcase
    end

    // Next state of the whole block
    always_comb begin
        d = q;
        // Bus handshake: one idle cycle with waitrequest high, then answer
        case (q.st)
            ifr_pkg::ST_IDLE: begin
                if (bus_req) begin
                    d.st       = ifr_pkg::ST_ANS;
                    d.wait_req = 1'b0;
                    d.rdata    = rd_val;
                end
            end
            ifr_pkg::ST_ANS: begin
                d.st       = ifr_pkg::ST_IDLE;
                d.wait_req = 1'b1;
            end
            default: begin
                d.st       = ifr_pkg::ST_IDLE;
                d.wait_req = 1'b1;
            end
        endcase

        // Software write replaces enabled lanes of implemented bits
        if (wr_take && avs_req_in.address == ifr_pkg::FLAGS0_OFS) begin
            d.flags0 = (q.flags0 & ~lane_mask) | (avs_req_in.writedata[15:0] & lane_mask);
        end
        if (wr_take && avs_req_in.address == ifr_pkg::FLAGS1_OFS) begin
            d.flags1 = (q.flags1 & ~lane_mask) | (avs_req_in.writedata[15:0] & lane_mask);
        end
        if (wr_take && avs_req_in.address == ifr_pkg::MASK_OFS && avs_req_in.byteenable[0]) begin
            d.mask = avs_req_in.writedata[1:0];
        end

        // Set applied after the write, so a request wins over a clear
        d.flags0 = (d.flags0 & ifr_pkg::IMPL0) | hw_set0;
        d.flags1 = (d.flags1 & ifr_pkg::IMPL1) | hw_set1;

        // Read clears only the bits that were actually returned
        if (rd_take && avs_req_in.address == ifr_pkg::STAT_OFS) begin
            d.stat = q.stat & ~q.rdata[1:0];
        end
        d.stat = d.stat | ev;
        d.irq  = |(d.stat & d.mask);
    end

    // Single state register, synchronous active-low reset
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            q.flags0   <= ifr_pkg::FLAGS_RST;
            q.flags1   <= ifr_pkg::FLAGS_RST;
            q.stat     <= ifr_pkg::STAT_RST;
            q.mask     <= ifr_pkg::MASK_RST;
            q.st       <= ifr_pkg::ST_IDLE;
            q.wait_req <= 1'b1;
            q.rdata    <= 32'h0000_0000;
            q.irq      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign avs_waitrequest_out = q.wait_req;
    assign avs_readdata_out    = q.rdata;
    assign flags_grp0_out      = q.flags0;
    assign flags_grp1_out      = q.flags1;
    assign irq_out             = q.irq;

    // Checks on flag, bus handshake and interrupt behaviour
    property p_req_sets0;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (hw_set0 != 16'h0000) |=> ((flags_grp0_out & $past(hw_set0)) == $past(hw_set0));
    endproperty
    a_req_sets0: assert property (p_req_sets0) else $error("group0 request not latched");

    property p_req_sets1;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (hw_set1 != 16'h0000) |=> ((flags_grp1_out & $past(hw_set1)) == $past(hw_set1));
    endproperty
    a_req_sets1: assert property (p_req_sets1) else $error("group1 request not latched");

    property p_idle_holds0;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (req_grp0_in == 16'h0000 && !avs_req_in.write) |=> $stable(flags_grp0_out);
    endproperty
    a_idle_holds0: assert property (p_idle_holds0)
        else $error("group0 flags moved unprompted");

    property p_unimpl0;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (flags_grp0_out & ~ifr_pkg::IMPL0) == 16'h0000;
    endproperty
    a_unimpl0: assert property (p_unimpl0) else $error("group0 unimplemented bit set");

    property p_unimpl1;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (flags_grp1_out & ~ifr_pkg::IMPL1) == 16'h0000;
    endproperty
    a_unimpl1: assert property (p_unimpl1) else $error("group1 unimplemented bit set");

    property p_reset_clear;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> (flags_grp0_out == 16'h0000 && flags_grp1_out == 16'h0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("flags not clear after reset");

    property p_write_zero0;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (wr_take && avs_req_in.address == ifr_pkg::FLAGS0_OFS
            && avs_req_in.byteenable[1:0] == 2'h3 && req_grp0_in == 16'h0000)
        |=> (flags_grp0_out == ($past(avs_req_in.writedata[15:0]) & ifr_pkg::IMPL0));
    endproperty
    a_write_zero0: assert property (p_write_zero0) else $error("group0 write not stored");

    property p_set_wins1;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (wr_take && avs_req_in.address == ifr_pkg::FLAGS1_OFS && hw_set1 != 16'h0000)
        |=> ((flags_grp1_out & $past(hw_set1)) == $past(hw_set1));
    endproperty
    a_set_wins1: assert property (p_set_wins1) else $error("software clear beat request");

    property p_wait_one;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (bus_req && avs_waitrequest_out) |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest timing wrong");

    property p_rd_upper_zero;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (avs_req_in.read && avs_waitrequest_out && avs_req_in.address == ifr_pkg::FLAGS0_OFS)
        |=> (avs_readdata_out == {16'h0000, $past(flags_grp0_out)});
    endproperty
    a_rd_upper_zero: assert property (p_rd_upper_zero)
        else $error("group0 read value wrong");

    property p_irq_level;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        irq_out == |(q.stat & q.mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

    // Group1 flags never move without a request or a bus write
    property p_idle_holds1;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (req_grp1_in == 16'h0000 && !avs_req_in.write) |=> $stable(flags_grp1_out);
    endproperty
    a_idle_holds1: assert property (p_idle_holds1)
        else $error("group1 flags moved unprompted");

    // Full-width group1 write with no request lands as written in the implemented bits
    property p_write_zero1;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (wr_take && avs_req_in.address == ifr_pkg::FLAGS1_OFS
            && avs_req_in.byteenable[1:0] == 2'h3 && req_grp1_in == 16'h0000)
        |=> (flags_grp1_out == ($past(avs_req_in.writedata[15:0]) & ifr_pkg::IMPL1));
    endproperty
    a_write_zero1: assert property (p_write_zero1)
        else $error("group1 write not stored");

    // Group0 request in the write cycle survives a software clear
    property p_set_wins0;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (wr_take && avs_req_in.address == ifr_pkg::FLAGS0_OFS && hw_set0 != 16'h0000)
        |=> ((flags_grp0_out & $past(hw_set0)) == $past(hw_set0));
    endproperty
    a_set_wins0: assert property (p_set_wins0)
        else $error("group0 clear beat request");

    // Without a bus write a pending flag stays pending; only software clears it
    property p_flags_keep;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !avs_req_in.write |=> ((flags_grp0_out & $past(flags_grp0_out)) == $past(flags_grp0_out)
            && (flags_grp1_out & $past(flags_grp1_out)) == $past(flags_grp1_out));
    endproperty
    a_flags_keep: assert property (p_flags_keep)
        else $error("pending flag dropped");

    // Group1 read returns the flags seen at the capture edge, upper half zero
    property p_rd_grp1;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (avs_req_in.read && avs_waitrequest_out && avs_req_in.address == ifr_pkg::FLAGS1_OFS)
        |=> (avs_readdata_out == {16'h0000, $past(flags_grp1_out)});
    endproperty
    a_rd_grp1: assert property (p_rd_grp1)
        else $error("group1 read value wrong");

    // Offsets outside the map answer zero so software never sees stale data
    property p_rd_unmapped;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (avs_req_in.read && avs_waitrequest_out
            && avs_req_in.address != ifr_pkg::FLAGS0_OFS
            && avs_req_in.address != ifr_pkg::FLAGS1_OFS
            && avs_req_in.address != ifr_pkg::STAT_OFS
            && avs_req_in.address != ifr_pkg::MASK_OFS)
        |=> (avs_readdata_out == 32'h0000_0000);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    // Waitrequest never stays low for more than one cycle
    property p_wait_low_one;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_wait_low_one: assert property (p_wait_low_one) else $error("waitrequest low too long");

    // Read data holds until the next request is captured
    property p_rdata_hold;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !bus_req |=> $stable(avs_readdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved while idle");

    // Every group event lands in the sticky status register
    property p_stat_sets;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ev != 2'h0) |=> ((q.stat & $past(ev)) == $past(ev));
    endproperty
    a_stat_sets: assert property (p_stat_sets) else $error("status event lost");

    // Status read with no new event clears every bit that was returned
    property p_stat_rd_clear;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_take && avs_req_in.address == ifr_pkg::STAT_OFS && ev == 2'h0)
        |=> ((q.stat & $past(q.rdata[1:0])) == 2'h0);
    endproperty
    a_stat_rd_clear: assert property (p_stat_rd_clear) else $error("status read did not clear");

    // Mask write needs the low byte lane
    property p_mask_write;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (wr_take && avs_req_in.address == ifr_pkg::MASK_OFS && avs_req_in.byteenable[0])
        |=> (q.mask == $past(avs_req_in.writedata[1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

    // An unmasked event raises the line on the next edge
    property p_irq_rise;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        ((ev & q.mask) != 2'h0 && !wr_take) |=> irq_out;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("unmasked event gave no interrupt");

    // Leaving reset the bus is quiet and the interrupt line low
    property p_rst_idle;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> (avs_waitrequest_out && !irq_out && avs_readdata_out == 32'h0000_0000);
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");

endmodule

// File: src/ifr_pkg.sv
/*
 * Constants, types and register map for the interrupt flag status block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses on a
 * single 100 MHz clock; peripheral requests arrive on that same clock.
 */
package ifr_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [3:0]  FLAGS0_OFS = 4'h0;
    localparam logic [3:0]  FLAGS1_OFS = 4'h4;
    localparam logic [3:0]  STAT_OFS   = 4'h8;
    localparam logic [3:0]  MASK_OFS   = 4'hC;

    // Implemented flag bits; zeros are unimplemented positions
    localparam logic [15:0] IMPL0 = 16'h3FEF;
    localparam logic [15:0] IMPL1 = 16'hFEDF;

    // Reset values
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [1:0]  STAT_RST  = 2'h0;
    localparam logic [1:0]  MASK_RST  = 2'h0;

    // Interrupt status bit positions
    localparam int EV_GRP0 = 0;
    localparam int EV_GRP1 = 1;

    // Bus handshake: waitrequest drops one cycle after a request appears
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_ANS  = 1'b1
    } ifr_bus_st_t;

    // Avalon-MM request group
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } ifr_avs_req_t;

    // Whole state of the block
    typedef struct packed {
        logic [15:0] flags0;
        logic [15:0] flags1;
        logic [1:0]  stat;
        logic [1:0]  mask;
        ifr_bus_st_t st;
        logic        wait_req;
        logic [31:0] rdata;
        logic        irq;
    } ifr_state_t;

endpackage

// File: verif/ifr_testbench.sv
/*
 * Self-checking bench for the interrupt flag status registers.
 * Assumes the ifr_pkg map, a single clock and the fixed one-wait bus answer.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  ref_clk_in = 1'b0;
    logic                  rst_n_in   = 1'b0;
    ifr_pkg::ifr_avs_req_t req        = '0;
    logic [15:0]           rq0        = 16'h0000;
    logic [15:0]           rq1        = 16'h0000;
    logic                  wreq;
    logic [31:0]           rdata;
    logic [15:0]           f0;
    logic [15:0]           f1;
    logic                  irq;
    logic [31:0]           exp_q[$];
    logic [31:0]           seed = 32'h518E;
    int                    miscompares = 0;
    int                    tests_run = 0;

    // Free-running 100 MHz clock
    always #5 ref_clk_in = ~ref_clk_in;

    ifr_flag_regs DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_req_in(req),
        .req_grp0_in(rq0), .req_grp1_in(rq1), .avs_waitrequest_out(wreq),
        .avs_readdata_out(rdata), .flags_grp0_out(f0), .flags_grp1_out(f1), .irq_out(irq));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp=%h got=%h", nm, e, g);
        end
    endtask

    task automatic summarize;
        if (exp_q.size() != 0) miscompares++;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One Avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_in);
        req.read <= ~wr;
        req.write <= wr;
        req.address <= a;
        req.byteenable <= 4'hF;
        req.writedata <= d;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0) begin
            miscompares++;
            summarize();
        end else begin
            req.read <= 1'b0;
            req.write <= 1'b0;
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // One-cycle request on a source line, then look at the flag outputs
    task automatic pulse(input int g, input int i);
        @(posedge ref_clk_in);
        if (g == 0) rq0[i] <= 1'b1;
        else rq1[i] <= 1'b1;
        @(posedge ref_clk_in);
        rq0 <= 16'h0000;
        rq1 <= 16'h0000;
        @(posedge ref_clk_in);
        #1;
    endtask

    // Read answers are checked at the edge that ends the wait
    always @(posedge ref_clk_in) begin
        if (rst_n_in && wreq === 1'b0 && req.read) begin
            if (exp_q.size() == 0) chk("stray_read", 32'h0, rdata);
            else chk("readdata", exp_q.pop_front(), rdata);
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd(ifr_pkg::FLAGS0_OFS, 16'h0000);
        rd(ifr_pkg::FLAGS1_OFS, 16'h0000);
        rd(ifr_pkg::STAT_OFS, 16'h0000);
        rd(ifr_pkg::MASK_OFS, 16'h0000);
        rd(4'h6, 16'h0000);
        bus(1'b1, ifr_pkg::FLAGS0_OFS, 32'hFFFF_FFFF);
        rd(ifr_pkg::FLAGS0_OFS, 16'h3FEF);
        bus(1'b1, ifr_pkg::FLAGS1_OFS, 32'h0000_FFFF);
        rd(ifr_pkg::FLAGS1_OFS, 16'hFEDF);
        bus(1'b1, ifr_pkg::FLAGS0_OFS, 32'h0000_0000);
        bus(1'b1, ifr_pkg::FLAGS1_OFS, 32'h0000_0000);
        rd(ifr_pkg::FLAGS0_OFS, 16'h0000);
        rd(ifr_pkg::FLAGS1_OFS, 16'h0000);
        // Walk every source line of both groups
        for (int i = 0; i < 16; i++) begin
            pulse(0, i);
            chk("flags0", {16'h0, (16'h0001 << i) & 16'h3FEF}, {16'h0, f0});
            rd(ifr_pkg::FLAGS0_OFS, (16'h0001 << i) & 16'h3FEF);
            bus(1'b1, ifr_pkg::FLAGS0_OFS, 32'h0);
            pulse(1, i);
            chk("flags1", {16'h0, (16'h0001 << i) & 16'hFEDF}, {16'h0, f1});
            rd(ifr_pkg::FLAGS1_OFS, (16'h0001 << i) & 16'hFEDF);
            bus(1'b1, ifr_pkg::FLAGS1_OFS, 32'h0);
        end
        rd(ifr_pkg::STAT_OFS, 16'h0003);
        rd(ifr_pkg::STAT_OFS, 16'h0000);
        // Masked event keeps the line low, unmasked one raises it
        bus(1'b1, ifr_pkg::MASK_OFS, 32'h1);
        pulse(1, 9);
        repeat (2) @(posedge ref_clk_in);
        #1 chk("irq_masked", 32'h0, {31'h0, irq});
        pulse(0, 0);
        repeat (2) @(posedge ref_clk_in);
        #1 chk("irq_set", 32'h1, {31'h0, irq});
        rd(ifr_pkg::STAT_OFS, 16'h0003);
        repeat (2) @(posedge ref_clk_in);
        #1 chk("irq_clear", 32'h0, {31'h0, irq});
        // Request held across a software clear must win
        @(posedge ref_clk_in);
        rq0[13] <= 1'b1;
        rq1[15] <= 1'b1;
        bus(1'b1, ifr_pkg::FLAGS0_OFS, 32'h0);
        bus(1'b1, ifr_pkg::FLAGS1_OFS, 32'h0);
        rq0 <= 16'h0000;
        rq1 <= 16'h0000;
        rd(ifr_pkg::FLAGS0_OFS, 16'h2000);
        rd(ifr_pkg::FLAGS1_OFS, 16'h8000);
        // Random writes and random request vectors
        repeat (8) begin
            seed = xs(seed);
            bus(1'b1, ifr_pkg::FLAGS1_OFS, seed);
            rd(ifr_pkg::FLAGS1_OFS, seed[15:0] & 16'hFEDF);
            bus(1'b1, ifr_pkg::FLAGS0_OFS, 32'h0);
            @(posedge ref_clk_in);
            rq0 <= seed[31:16];
            @(posedge ref_clk_in);
            rq0 <= 16'h0000;
            rd(ifr_pkg::FLAGS0_OFS, seed[31:16] & 16'h3FEF);
        end
        // Reset in mid-run must clear flags, status and mask
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd(ifr_pkg::FLAGS0_OFS, 16'h0000);
        rd(ifr_pkg::FLAGS1_OFS, 16'h0000);
        rd(ifr_pkg::STAT_OFS, 16'h0000);
        rd(ifr_pkg::MASK_OFS, 16'h0000);
        #1 chk("irq_reset", 32'h0, {31'h0, irq});
        repeat (3) @(posedge ref_clk_in);
        summarize();
    end
endmodule
